// ### utx_pkg.sv
// Purpose: constants shared by the UART transmit path
// Assumes: one 20 MHz clock, registers reached through write strobes
// Notes:   bit positions follow the register layouts of the device
package utx_pkg;
   // ***************************************************
   // Storage sizes
   // ***************************************************
   localparam int unsigned FIFO_DEPTH = 64;
   localparam int unsigned PTR_W      = 6;
   localparam int unsigned CNT_W      = 7;
   localparam logic [6:0]  CNT_FULL   = 7'h40;
   localparam logic [6:0]  CNT_ONE    = 7'h01;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] DIV_LOW_RST  = 8'h01;
   localparam logic [7:0] DIV_HIGH_RST = 8'h00;
   localparam logic [7:0] FRAC_RST     = 8'h00;
   localparam logic [7:0] QCTRL_RST    = 8'h00;
   localparam logic [7:0] IEN_RST      = 8'h00;
   localparam logic [7:0] MODEM_RST    = 8'h00;
   localparam logic [7:0] LCTRL_RST    = 8'h03;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int unsigned QCTRL_FIFO_EN_BIT = 0;
   localparam int unsigned IEN_TX_EMPTY_BIT  = 1;
   localparam int unsigned CAUSE_TX_BIT      = 1;
   localparam int unsigned LS_HOLD_EMPTY_BIT = 5;
   localparam int unsigned LS_SHIFT_EMPTY_BIT = 6;
   localparam int unsigned MODEM_PRESC_BIT   = 7;
   localparam int unsigned FRAC_LSB          = 0;
   localparam int unsigned MODE_LSB          = 4;
   localparam int unsigned LC_STOP_BIT       = 2;
   localparam int unsigned LC_PAR_EN_BIT     = 3;
   localparam int unsigned LC_PAR_EVEN_BIT   = 4;

   // ***************************************************
   // Sampling modes and bit periods
   // ***************************************************
   localparam logic [1:0] MODE_16X = 2'h0;
   localparam logic [1:0] MODE_8X  = 2'h1;
   localparam logic [1:0] MODE_4X  = 2'h2;
   localparam logic [4:0] TICKS_16X = 5'h10;
   localparam logic [4:0] TICKS_8X  = 5'h08;
   localparam logic [4:0] TICKS_4X  = 5'h04;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [20:0] ACC_STEP = 21'h0_0010;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_START  = 5'h02,
      ST_DATA   = 5'h04,
      ST_PARITY = 5'h08,
      ST_STOP   = 5'h10
   } utx_state_t;
endpackage : utx_pkg

// ### utx_transmitter.sv
// Purpose: transmit path of one UART channel with fractional divider
// Assumes: host write strobes are single-cycle pulses; 20 MHz clock
// Notes:   receiver, flow control and trigger levels are not here
//
// Notes on behaviour
// - Eight-bit shifter fed by a 64-byte queue entered via holding byte.
// - One serial bit lasts 16, 8 or 4 sampling ticks.
// - Character is start, data bits, optional parity, then stop bits.
// - Data bits go out least significant bit first.
// - With queue enabled, holding-byte writes go into the 64-byte queue.
// - Each accepted holding-byte write advances the write pointer by one; in a flush cycle it is set to 1.
// - Holding-empty flag sets when the last stored byte moves into the shifter.
// - Holding-empty raises transmit interrupt only while its enable is set.
// - Shifter-empty flag sets once nothing at all is left to send.
// - After reset the queue is disabled.
// - Divider reproduces table rates, e.g. 0/9C/4 gives 9600 at 24 MHz.
// - Mode code 00 selects 16X, 01 selects 8X, 10 selects 4X.
// - Low four fraction bits add 0 to 15/16 to the divisor.
// - Prescaler passes the clock or divides it by 4.
// - After reset the divisor is 1 with fraction zero.
`timescale 1ns/100ps
`default_nettype none
module utx_transmitter (
   input  wire logic       sys_clk_in,        // 20 MHz clock
   input  wire logic       arst_n_in,         // Async reset, low
   input  wire logic [7:0] wr_data_in,        // Write data for all strobes
   input  wire logic       hold_wr_in,        // Write tx_holding_byte
   input  wire logic       qctrl_wr_in,       // Write queue_control_reg
   input  wire logic       ien_wr_in,         // Write irq_enable_reg
   input  wire logic       lctrl_wr_in,       // Write line format
   input  wire logic       div_low_wr_in,     // Write divisor low byte
   input  wire logic       div_high_wr_in,    // Write divisor_high_byte
   input  wire logic       frac_wr_in,        // Write fraction_and_sampling_reg
   input  wire logic       modem_wr_in,       // Write modem_control_reg
   output logic [7:0]      line_state_out,    // line_state_reg view
   output logic [7:0]      irq_cause_out,     // irq_cause_reg view
   output logic            tx_irq_out,        // Transmit-empty interrupt
   output logic            txd_out            // Serial output
);
   // ***************************************************
   // Registers
   // ***************************************************
   logic [7:0] qctrl_q, ien_q, lctrl_q, div_low_q, div_high_q;
   logic [7:0] frac_q, modem_q;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         qctrl_q    <= utx_pkg::QCTRL_RST;
         ien_q      <= utx_pkg::IEN_RST;
         lctrl_q    <= utx_pkg::LCTRL_RST;
         div_low_q  <= utx_pkg::DIV_LOW_RST;
         div_high_q <= utx_pkg::DIV_HIGH_RST;
         frac_q     <= utx_pkg::FRAC_RST;
         modem_q    <= utx_pkg::MODEM_RST;
      end else begin
         if (qctrl_wr_in) qctrl_q <= wr_data_in;
         if (ien_wr_in) ien_q <= wr_data_in;
         if (lctrl_wr_in) lctrl_q <= wr_data_in;
         if (div_low_wr_in) div_low_q <= wr_data_in;
         if (div_high_wr_in) div_high_q <= wr_data_in;
         if (frac_wr_in) frac_q <= wr_data_in;
         if (modem_wr_in) modem_q <= wr_data_in;
      end
   end

   logic fifo_en;
   logic [1:0] mode;
   assign fifo_en = qctrl_q[utx_pkg::QCTRL_FIFO_EN_BIT];
   assign mode    = frac_q[utx_pkg::MODE_LSB +: 2];

   // ***************************************************
   // Prescaler and fractional divider
   // ***************************************************
   logic [1:0]  presc_q;
   logic        presc_tick;
   logic [20:0] acc_q, acc_sum, div16;
   logic        samp_q;

   assign presc_tick = !modem_q[utx_pkg::MODEM_PRESC_BIT]
                       || (presc_q == utx_pkg::PRESC_LAST);
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) presc_q <= 2'h0;
      else presc_q <= presc_q + 2'h1;
   end

   assign div16   = {1'b0, div_high_q, div_low_q, frac_q[utx_pkg::FRAC_LSB +: 4]};
   assign acc_sum = acc_q + utx_pkg::ACC_STEP;

   // sixteenths accumulate, tick on overflow of divisor
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc_q  <= 21'h0_0000;
         samp_q <= 1'b0;
      end else begin
         samp_q <= 1'b0;
         if (presc_tick) begin
            if (acc_sum >= div16) begin
               acc_q  <= acc_sum - div16;
               samp_q <= 1'b1;
            end else begin
               acc_q <= acc_sum;
            end
         end
      end
   end

   logic [4:0] bit_ticks;
   always_comb begin
      case (mode)
         utx_pkg::MODE_8X: bit_ticks = utx_pkg::TICKS_8X;
         utx_pkg::MODE_4X: bit_ticks = utx_pkg::TICKS_4X;
         default:          bit_ticks = utx_pkg::TICKS_16X;
      endcase
   end

   // ***************************************************
   // Holding byte and queue
   // ***************************************************
   logic [7:0]             mem_q [utx_pkg::FIFO_DEPTH];
   logic [utx_pkg::PTR_W-1:0] wp_q, rp_q;
   logic [utx_pkg::CNT_W-1:0] cnt_q;
   logic                   full, push, pop, fifo_en_d1_q, flush;
   logic [utx_pkg::PTR_W-1:0] wr_idx;

   assign flush  = (fifo_en != fifo_en_d1_q);
   // A write in the flush cycle becomes the first entry, so none is lost
   assign wr_idx = flush ? '0 : wp_q;
   // Without the queue only one byte is held; extra writes are dropped
   assign full = fifo_en ? (cnt_q == utx_pkg::CNT_FULL)
                         : (cnt_q >= utx_pkg::CNT_ONE);
   assign push = hold_wr_in && (flush || !full);

   always_ff @(posedge sys_clk_in) begin
      if (push) mem_q[wr_idx] <= wr_data_in;
   end

   // Switching the queue on or off flushes it, as a fresh start
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         fifo_en_d1_q <= 1'b0;
      end else begin
         fifo_en_d1_q <= fifo_en;
         if (flush) begin
            wp_q  <= push ? 6'h01 : 6'h00;
            rp_q  <= '0;
            cnt_q <= push ? 7'h01 : 7'h00;
         end else begin
            if (push) wp_q <= wp_q + 6'h01;
            if (pop) rp_q <= rp_q + 6'h01;
            if (push && !pop) cnt_q <= cnt_q + 7'h01;
            else if (pop && !push) cnt_q <= cnt_q - 7'h01;
         end
      end
   end

   // ***************************************************
   // Shifter and frame sequencer
   // ***************************************************
   utx_pkg::utx_state_t state_q;
   logic [7:0] shreg_q;
   logic [4:0] sub_q;
   logic [2:0] bitn_q;
   logic       stop2_q, par_q, txd_q;
   logic       bit_end, have_data;
   logic [2:0] last_bit;

   assign bit_end   = samp_q && (sub_q == bit_ticks - 5'h01);
   assign have_data = (cnt_q != '0) && (fifo_en == fifo_en_d1_q);
   assign last_bit  = {1'b1, lctrl_q[1:0]};
   // load at idle or straight after the final stop bit
   assign pop = have_data && ((state_q == utx_pkg::ST_IDLE)
                || (state_q == utx_pkg::ST_STOP && bit_end && !stop2_q));

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) sub_q <= 5'h00;
      else if (state_q == utx_pkg::ST_IDLE || bit_end) sub_q <= 5'h00;
      else if (samp_q) sub_q <= sub_q + 5'h01;
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= utx_pkg::ST_IDLE;
         shreg_q <= 8'h00;
         bitn_q  <= 3'h0;
         stop2_q <= 1'b0;
         par_q   <= 1'b0;
         txd_q   <= 1'b1;
      end else begin
         case (state_q)
            utx_pkg::ST_IDLE: begin
               txd_q <= 1'b1;
               if (pop) begin
                  shreg_q <= mem_q[rp_q];
                  state_q <= utx_pkg::ST_START;
                  txd_q   <= 1'b0;
               end
            end
            utx_pkg::ST_START: if (bit_end) begin
               txd_q   <= shreg_q[0];
               par_q   <= shreg_q[0] ^ !lctrl_q[utx_pkg::LC_PAR_EVEN_BIT];
               shreg_q <= {1'b0, shreg_q[7:1]};
               bitn_q  <= 3'h0;
               state_q <= utx_pkg::ST_DATA;
            end
            utx_pkg::ST_DATA: if (bit_end) begin
               if (bitn_q == last_bit) begin
                  if (lctrl_q[utx_pkg::LC_PAR_EN_BIT]) begin
                     txd_q   <= par_q;
                     state_q <= utx_pkg::ST_PARITY;
                  end else begin
                     txd_q   <= 1'b1;
                     stop2_q <= lctrl_q[utx_pkg::LC_STOP_BIT];
                     state_q <= utx_pkg::ST_STOP;
                  end
               end else begin
                  txd_q   <= shreg_q[0];
                  par_q   <= par_q ^ shreg_q[0];
                  shreg_q <= {1'b0, shreg_q[7:1]};
                  bitn_q  <= bitn_q + 3'h1;
               end
            end
            utx_pkg::ST_PARITY: if (bit_end) begin
               txd_q   <= 1'b1;
               stop2_q <= lctrl_q[utx_pkg::LC_STOP_BIT];
               state_q <= utx_pkg::ST_STOP;
            end
            utx_pkg::ST_STOP: if (bit_end) begin
               if (stop2_q) begin
                  stop2_q <= 1'b0;
               end else if (pop) begin
                  shreg_q <= mem_q[rp_q];
                  txd_q   <= 1'b0;
                  state_q <= utx_pkg::ST_START;
               end else begin
                  state_q <= utx_pkg::ST_IDLE;
               end
            end
            default: state_q <= utx_pkg::ST_IDLE;
         endcase
      end
   end

   // ***************************************************
   // Status and interrupt
   // ***************************************************
   logic hold_empty, shift_empty;
   // empty once byte left holding storage
   assign hold_empty  = (cnt_q == '0);
   assign shift_empty = hold_empty && (state_q == utx_pkg::ST_IDLE);

   always_comb begin
      line_state_out = 8'h00;
      line_state_out[utx_pkg::LS_HOLD_EMPTY_BIT]  = hold_empty;
      line_state_out[utx_pkg::LS_SHIFT_EMPTY_BIT] = shift_empty;
      irq_cause_out = 8'h00;
      irq_cause_out[utx_pkg::CAUSE_TX_BIT] = tx_irq_out;
   end
   assign tx_irq_out = hold_empty && ien_q[utx_pkg::IEN_TX_EMPTY_BIT];
   assign txd_out    = txd_q;

   // ***************************************************
   // Checks
   // ***************************************************
   idle_high_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      state_q == utx_pkg::ST_IDLE && $past(state_q) == utx_pkg::ST_IDLE
      |-> txd_out) else $error("line not high when idle");
   start_low_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      state_q == utx_pkg::ST_START |-> !txd_out)
      else $error("start bit not low");
   lsb_first_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      state_q == utx_pkg::ST_START && bit_end
      |=> txd_out == $past(shreg_q[0])) else $error("first data bit not bit 0");
   tick_bound_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      state_q != utx_pkg::ST_IDLE |-> sub_q < bit_ticks)
      else $error("bit longer than sampling period");
   ptr_bump_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      push && fifo_en == fifo_en_d1_q |=> wp_q == $past(wp_q) + 6'h01)
      else $error("write pointer did not advance");
   queue_fill_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      fifo_en && fifo_en_d1_q && cnt_q == 7'h01 && hold_wr_in && !pop
      |=> cnt_q == 7'h02) else $error("queue did not take byte");
   hold_empty_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      !fifo_en && fifo_en_d1_q == fifo_en && pop
      |=> line_state_out[utx_pkg::LS_HOLD_EMPTY_BIT] || $past(push))
      else $error("holding empty not set on transfer");
   tx_irq_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      tx_irq_out |-> ien_q[utx_pkg::IEN_TX_EMPTY_BIT]
      && line_state_out[utx_pkg::LS_HOLD_EMPTY_BIT])
      else $error("interrupt without enable or empty");
   shift_empty_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      line_state_out[utx_pkg::LS_SHIFT_EMPTY_BIT]
      |-> txd_out && line_state_out[utx_pkg::LS_HOLD_EMPTY_BIT])
      else $error("shifter empty while sending");
   div_one_a: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      $past(div16) == 21'h0_0010 && !$past(modem_q[utx_pkg::MODEM_PRESC_BIT])
      && $past(samp_q) |-> samp_q) else $error("divisor one not every cycle");
endmodule : utx_transmitter
`default_nettype wire

// ### utx_remote_rx.sv
// Purpose: remote serial receiver that samples the transmit line
// Assumes: line idles high; bit length and frame size set by the bench
// Notes:   samples on the falling clock edge, clear of the line's updates
`timescale 1ns/100ps
`default_nettype none
module utx_remote_rx (
   input  wire logic        sys_clk_in,  // Bench clock
   input  wire logic        txd_in,      // Serial line from the block
   input  wire logic [15:0] bit_len_in,  // Clocks per serial bit
   input  wire logic [3:0]  nbits_in,    // Bits per frame, start to last stop
   output var  logic [11:0] frame_out,   // Sampled bits, start bit in bit 0
   output var  logic        done_out     // High for one clock per frame
);
   int unsigned i;

   initial begin
      frame_out = 12'h000;
      done_out  = 1'b0;
      forever begin
         @(negedge txd_in);
         // Mid-bit sampling tolerates the fractional divider's jitter
         repeat (bit_len_in / 2) @(negedge sys_clk_in);
         for (i = 0; i < nbits_in; i++) begin
            frame_out[i] = txd_in;
            if (i + 1 < nbits_in) repeat (bit_len_in) @(negedge sys_clk_in);
         end
         done_out = 1'b1;
         @(negedge sys_clk_in);
         done_out = 1'b0;
      end
   end
endmodule : utx_remote_rx
`default_nettype wire

// ### test_uart_transmitter_with_fractional_brg.sv
// Purpose: self-checking bench for the UART transmit path
// Assumes: 20 MHz clock, inputs driven on the falling edge
// Notes:   frames are judged by the remote receiver model
`timescale 1ns/100ps
`default_nettype none
module test_uart_transmitter_with_fractional_brg;
   typedef struct {
      logic [7:0] frac, dl, mdm, lc, data;
      int         len;
   } utx_row_t;

   logic        sys_clk_in, arst_n_in, tx_irq, txd, done;
   logic [7:0]  wr_data, strb, line_state, irq_cause;
   logic [11:0] frame;
   logic [15:0] bit_len;
   logic [3:0]  nb;
   int          n_mismatch = 0, checked = 0, cyc = 0, t_last = 0;
   // Columns: fraction/mode, divisor low, modem, format, data, clocks per bit
   utx_row_t    rows [10] = '{
      '{8'h00, 8'h01, 8'h00, 8'h03, 8'hA5, 16}, '{8'h10, 8'h01, 8'h00, 8'h03, 8'h3C, 8},
      '{8'h20, 8'h01, 8'h00, 8'h03, 8'hC3, 4},  '{8'h00, 8'h02, 8'h00, 8'h03, 8'h5A, 32},
      '{8'h08, 8'h01, 8'h00, 8'h03, 8'h96, 24}, '{8'h00, 8'h01, 8'h80, 8'h03, 8'h69, 64},
      '{8'h20, 8'h01, 8'h00, 8'h1E, 8'h4B, 4},  '{8'h20, 8'h01, 8'h00, 8'h08, 8'h13, 4},
      '{8'h30, 8'h01, 8'h00, 8'h03, 8'h2D, 16}, '{8'h24, 8'h9C, 8'h00, 8'h03, 8'hE1, 625}};

   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end

   always @(negedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         results();
      end
   end

   utx_transmitter utx_transmitter_inst (
      .sys_clk_in     (sys_clk_in),
      .arst_n_in      (arst_n_in),
      .wr_data_in     (wr_data),
      .hold_wr_in     (strb[0]),
      .qctrl_wr_in    (strb[1]),
      .ien_wr_in      (strb[2]),
      .lctrl_wr_in    (strb[3]),
      .div_low_wr_in  (strb[4]),
      .div_high_wr_in (strb[5]),
      .frac_wr_in     (strb[6]),
      .modem_wr_in    (strb[7]),
      .line_state_out (line_state),
      .irq_cause_out  (irq_cause),
      .tx_irq_out     (tx_irq),
      .txd_out        (txd)
   );

   utx_remote_rx utx_remote_rx_inst (
      .sys_clk_in (sys_clk_in),
      .txd_in     (txd),
      .bit_len_in (bit_len),
      .nbits_in   (nb),
      .frame_out  (frame),
      .done_out   (done)
   );

   // ***************************************************
   // Helpers
   // ***************************************************
   task automatic results();
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [7:0] lc,
                                             output int n);
      logic [11:0] f;
      logic        p;
      int          len;
      len = 5 + int'(lc[1:0]);
      f = 12'hFFF;
      f[0] = 1'b0;
      p = 1'b0;
      for (int k = 0; k < len; k++) begin
         f[k + 1] = d[k];
         p ^= d[k];
      end
      n = len + 1;
      if (lc[3]) begin
         f[n] = lc[4] ? p : ~p;
         n++;
      end
      n = n + (lc[2] ? 2 : 1);
      return f;
   endfunction : exp_frame

   // Strobe index: 0 hold, 1 queue, 2 irq enable, 3 format, 4 low, 5 high, 6 frac, 7 modem
   task automatic wr(input int sel, input logic [7:0] d);
      @(negedge sys_clk_in);
      strb[sel] = 1'b1;
      wr_data = d;
      @(negedge sys_clk_in);
      strb = 8'h00;
   endtask : wr

   task automatic cfg(input utx_row_t r);
      int n;
      // Mode changes only between frames, or the bit counter overruns
      while (line_state[6] !== 1'b1) @(negedge sys_clk_in);
      wr(6, r.frac);
      wr(4, r.dl);
      wr(5, 8'h00);
      wr(7, r.mdm);
      wr(3, r.lc);
      void'(exp_frame(8'h00, r.lc, n));
      nb = n[3:0];
      bit_len = r.len[15:0];
   endtask : cfg

   // Waits for one received frame; b2b also demands no idle time before it
   task automatic frame_chk(input logic [7:0] lc, input logic [7:0] d, input bit b2b);
      logic [11:0] e, m;
      int          n, w;
      e = exp_frame(d, lc, n);
      m = (12'h001 << n) - 12'h001;
      w = 0;
      do begin
         @(posedge sys_clk_in);
         w++;
      end while (done !== 1'b1 && w < 8000);
      chk("frame", {4'h0, e & m}, {4'h0, frame & m});
      if (b2b) chk("gap", 16'(n * int'(bit_len)), 16'(cyc - t_last));
      t_last = cyc;
   endtask : frame_chk

   task automatic no_more(input int cycles);
      int extra;
      extra = 0;
      repeat (cycles) begin
         @(posedge sys_clk_in);
         if (done === 1'b1) extra++;
      end
      chk("extra_frames", 16'h0000, 16'(extra));
      chk("ls_idle", 16'h0060, {8'h00, line_state});
   endtask : no_more

   task automatic do_reset();
      @(negedge sys_clk_in);
      arst_n_in = 1'b0;
      repeat (10) @(negedge sys_clk_in);
      chk("txd_reset", 16'h0001, {15'h0000, txd});
      chk("ls_reset", 16'h0060, {8'h00, line_state});
      chk("irq_reset", 16'h0000, {7'h00, tx_irq, irq_cause});
      arst_n_in = 1'b1;
      nb = 4'hA;
      bit_len = 16'h0010;
   endtask : do_reset

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      arst_n_in = 1'b0;
      strb = 8'h00;
      wr_data = 8'h00;
      nb = 4'hA;
      bit_len = 16'h0010;
      do_reset();
      wr(0, 8'h3A);
      frame_chk(8'h03, 8'h3A, 1'b0);
      foreach (rows[i]) begin
         cfg(rows[i]);
         wr(0, rows[i].data);
         frame_chk(rows[i].lc, rows[i].data, 1'b0);
      end
      // Holding byte without the queue, interrupt enabled then masked
      cfg(rows[2]);
      wr(2, 8'h02);
      wr(0, 8'h81);
      repeat (2) @(negedge sys_clk_in);
      chk("ls_moved", 16'h0020, {8'h00, line_state});
      chk("irq_on", 16'h0102, {7'h00, tx_irq, irq_cause});
      wr(0, 8'h7E);
      chk("ls_held", 16'h0000, {8'h00, line_state});
      chk("irq_off", 16'h0000, {7'h00, tx_irq, irq_cause});
      frame_chk(8'h03, 8'h81, 1'b0);
      frame_chk(8'h03, 8'h7E, 1'b1);
      no_more(8);
      wr(2, 8'h00);
      wr(0, 8'h55);
      repeat (2) @(negedge sys_clk_in);
      chk("irq_masked", 16'h0000, {7'h00, tx_irq, irq_cause});
      frame_chk(8'h03, 8'h55, 1'b0);
      // Queue on: one byte goes to the shifter, 64 are stored, the last is dropped
      // Long bits, so the first frame outlasts the burst of writes
      cfg(rows[0]);
      wr(1, 8'h01);
      @(negedge sys_clk_in);
      for (int k = 0; k < 66; k++) begin
         strb[0] = 1'b1;
         wr_data = 8'(k);
         @(negedge sys_clk_in);
      end
      strb = 8'h00;
      chk("ls_full", 16'h0000, {8'h00, line_state});
      for (int k = 0; k < 65; k++) frame_chk(8'h03, 8'(k), k > 0);
      no_more(120);
      // Second reset mid-run: defaults back, queue off holds one byte only
      do_reset();
      wr(0, 8'hC6);
      wr(0, 8'h39);
      wr(0, 8'h0F);
      frame_chk(8'h03, 8'hC6, 1'b0);
      frame_chk(8'h03, 8'h39, 1'b1);
      no_more(400);
      results();
   end
endmodule : test_uart_transmitter_with_fractional_brg
`default_nettype wire
